// [lvt_pkg.sv]
package lvt_pkg;

  // register numbers on the management port
  localparam logic [15:0] LOOKUP_CMD_ADDR   = 16'h1802;
  localparam logic [15:0] READ_LOWER_ADDR   = 16'h1805;
  localparam logic [15:0] READ_UPPER_ADDR   = 16'h1806;
  localparam logic [15:0] STATUS_ADDR       = 16'h1808;
  localparam logic [15:0] CONFIG_ADDR       = 16'h1809;
  localparam logic [15:0] VLAN_CMD_ADDR     = 16'h180B;
  localparam logic [15:0] VLAN_WDATA_ADDR   = 16'h180C;
  localparam logic [15:0] VLAN_RDATA_ADDR   = 16'h180D;
  localparam logic [15:0] VLAN_STATUS_ADDR  = 16'h180E;

  // field positions
  localparam int CMD_GET_NEXT_BIT   = 0;
  localparam int CMD_GET_FIRST_BIT  = 1;
  localparam int CMD_MAKE_BIT       = 2;
  localparam int STS_MAKE_PEND_BIT  = 0;
  localparam int STS_INIT_DONE_BIT  = 1;
  localparam int CFG_AGE_TEST_BIT   = 0;
  localparam int ACCESS_DIRECTION_BIT       = 5;
  localparam int VLAN_SEL_BIT       = 4;
  localparam int VLAN_IDX_LSB       = 0;
  localparam int VLAN_IDX_W         = 4;
  localparam int VLAN_PEND_BIT      = 0;
  localparam int VLAN_DATA_W        = 18;
  localparam int PVID_DATA_W        = 15;
  localparam int VLAN_ENTRIES       = 16;
  localparam int PVID_ENTRIES       = 3;

  // reset values
  localparam logic [14:0] PVID_RESET   = 15'h0001;
  localparam logic [17:0] VLAN_RESET   = 18'h00000;
  localparam logic [31:0] READ_ZERO    = 32'h00000000;

  // timing
  localparam int AGE_W                      = 40;
  localparam longint unsigned CLK_FREQ_HZ   = 25000000;
  localparam longint unsigned CLK_PERIOD_NS = 40;
  localparam longint unsigned INIT_TIME_NS  = 20000;
  localparam longint unsigned AGE_NORMAL_MIN = 5;
  localparam longint unsigned AGE_TEST_MS   = 50;
  localparam logic [AGE_W-1:0] INIT_CYCLES =
    AGE_W'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [AGE_W-1:0] AGE_NORMAL_CYCLES =
    AGE_W'(AGE_NORMAL_MIN * 60 * CLK_FREQ_HZ);
  localparam logic [AGE_W-1:0] AGE_TEST_CYCLES =
    AGE_W'(AGE_TEST_MS * CLK_FREQ_HZ / 1000);
  localparam logic [1:0] VLAN_ACCESS_CYCLES = 2'h2;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lvt_reg_req_t;

  typedef struct packed {
    logic [31:0] mac_first;
    logic        is_static;
    logic        filter;
    logic        prio_en;
    logic [2:0]  prio;
    logic [2:0]  port;
    logic [15:0] mac_last;
  } lvt_entry_t;

  typedef struct packed {
    logic make;
    logic get_first;
    logic get_next;
  } lvt_lookup_cmd_t;

  typedef struct packed {
    logic       rnw;
    logic       pvid_sel;
    logic [3:0] index;
  } lvt_vlan_cmd_t;

  typedef enum logic [0:0] {
    VLAN_IDLE = 1'b0,
    VLAN_BUSY = 1'b1
  } lvt_vlan_state_t;

endpackage

// [lvt_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module lvt_timer #(
  parameter int W = 40
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_run,
  input  wire logic         i_restart,
  input  wire logic [W-1:0] i_period,
  output logic              o_expire
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_expire;

  if (W < 2) begin : g_chk
    $error("lvt_timer width too small");
  end

  // periodic count; restart or a stop puts it back to zero
  always_comb begin
    next_cnt    = cnt;
    next_expire = 1'b0;
    if (i_restart || !i_run) begin
      next_cnt = '0;
    end else if (cnt >= i_period - W'(1)) begin
      next_cnt    = '0;
      next_expire = 1'b1;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt      <= '0;
      o_expire <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      o_expire <= next_expire;
    end
  end

endmodule
`default_nettype wire

// [lvt_regs.sv]
// Function
// R1: port field encodes single port or group
// R2: low upper-word bits hold last MAC bits
// R3: init-done reads 0, self-sets, not writable
// R4: table init runs after every fabric reset
// R5: init about 20 us, drop packets meanwhile
// R6: software waits for init-done before writing
// R7: make-pending set during entry creation command
// R8: age test shortens aging to 50 ms
// R9: each VLAN command write launches one access
// R10: read pending until done, then read data
// R11: write data loaded first, pending shows completion
// R12: bit 5 selects read or write
// R13: bit 4 selects port VID or VLAN
// R14: index 0-15 or 0-2, else undefined
// R15: valid clears on get command, sets on find
// R16: command writes ignored while access pending
`timescale 1ns/1ps
`default_nettype none
module lvt_regs #(
  parameter logic [39:0] AGE_NORMAL_CYCLES = lvt_pkg::AGE_NORMAL_CYCLES,
  parameter logic [39:0] AGE_TEST_CYCLES   = lvt_pkg::AGE_TEST_CYCLES
) (
  input  wire logic                      I_MCLK,
  input  wire logic                      I_RST_N,
  input  wire lvt_pkg::lvt_reg_req_t     I_REG_REQ,
  output logic [31:0]                    O_REG_RDATA,
  output logic                           O_REG_ACK,
  input  wire lvt_pkg::lvt_entry_t       I_ENTRY,
  input  wire logic                      I_ENTRY_FOUND,
  input  wire logic                      I_END_OF_TABLE,
  input  wire logic                      I_MAKE_DONE,
  output var lvt_pkg::lvt_lookup_cmd_t   O_LOOKUP_CMD,
  output logic                           O_RX_DROP,
  output logic                           O_AGE_TICK
);

  if (AGE_TEST_CYCLES < 40'h2 || AGE_NORMAL_CYCLES < 40'h2) begin : g_chk
    $error("aging periods must be at least two cycles");
  end

  localparam int VW = lvt_pkg::VLAN_DATA_W;
  localparam int PW = lvt_pkg::PVID_DATA_W;

  logic                      init_done;
  logic                      next_init_done;
  logic                      init_expire;
  logic                      age_expire;
  logic                      age_test;
  logic                      next_age_test;
  logic                      make_pending;
  logic                      next_make_pending;
  logic                      entry_valid;
  logic                      next_entry_valid;
  logic                      end_of_table;
  logic                      next_end_of_table;
  lvt_pkg::lvt_entry_t       entry;
  lvt_pkg::lvt_entry_t       next_entry;
  lvt_pkg::lvt_lookup_cmd_t  next_lookup_cmd;
  lvt_pkg::lvt_vlan_cmd_t    vlan_cmd;
  lvt_pkg::lvt_vlan_cmd_t    next_vlan_cmd;
  lvt_pkg::lvt_vlan_state_t  vstate;
  lvt_pkg::lvt_vlan_state_t  next_vstate;
  logic [1:0]                vwait;
  logic [1:0]                next_vwait;
  logic [VW-1:0]             vlan_wdata;
  logic [VW-1:0]             next_vlan_wdata;
  logic [VW-1:0]             vlan_rdata;
  logic [VW-1:0]             next_vlan_rdata;
  logic [VW-1:0]             vlan_tab [lvt_pkg::VLAN_ENTRIES];
  logic [VW-1:0]             next_vlan_tab [lvt_pkg::VLAN_ENTRIES];
  logic [PW-1:0]             pvid_tab [lvt_pkg::PVID_ENTRIES];
  logic [PW-1:0]             next_pvid_tab [lvt_pkg::PVID_ENTRIES];
  logic [31:0]               next_rdata;
  logic                      wr_cmd;
  logic                      wr_cfg;
  logic                      wr_vlan_cmd;
  logic                      vlan_accept;
  logic                      vlan_pend;
  logic [39:0]               age_period;

  assign wr_cmd      = I_REG_REQ.wr &&
                       I_REG_REQ.addr == lvt_pkg::LOOKUP_CMD_ADDR;
  assign wr_cfg      = I_REG_REQ.wr &&
                       I_REG_REQ.addr == lvt_pkg::CONFIG_ADDR;
  assign wr_vlan_cmd = I_REG_REQ.wr &&
                       I_REG_REQ.addr == lvt_pkg::VLAN_CMD_ADDR;
  assign vlan_pend   = (vstate == lvt_pkg::VLAN_BUSY);
  // a command write during a busy access is dropped to protect it
  assign vlan_accept = wr_vlan_cmd && !vlan_pend; // R16 R9
  assign age_period  = age_test ? AGE_TEST_CYCLES
                                : AGE_NORMAL_CYCLES; // R8

  // table init timer; restarts from zero on every reset
  lvt_timer #(
    .W (lvt_pkg::AGE_W)
  ) u_init_timer (
    .i_clk     (I_MCLK),
    .i_rst_n   (I_RST_N),
    .i_run     (!init_done), // R4
    .i_restart (1'b0),
    .i_period  (lvt_pkg::INIT_CYCLES), // R5
    .o_expire  (init_expire)
  );

  // aging timer; a config write restarts so the new period applies at once
  lvt_timer #(
    .W (lvt_pkg::AGE_W)
  ) u_age_timer (
    .i_clk     (I_MCLK),
    .i_rst_n   (I_RST_N),
    .i_run     (init_done),
    .i_restart (wr_cfg),
    .i_period  (age_period),
    .o_expire  (age_expire)
  );

  // lookup status, config and read-result state
  always_comb begin
    next_init_done    = init_done | init_expire; // R3
    next_age_test     = age_test;
    next_make_pending = make_pending;
    next_entry_valid  = entry_valid;
    next_end_of_table = end_of_table;
    next_entry        = entry;
    next_lookup_cmd   = '0;
    if (wr_cfg) begin
      next_age_test = I_REG_REQ.wdata[lvt_pkg::CFG_AGE_TEST_BIT]; // R8
    end
    if (wr_cmd) begin
      next_lookup_cmd.make      = I_REG_REQ.wdata[lvt_pkg::CMD_MAKE_BIT];
      next_lookup_cmd.get_first =
        I_REG_REQ.wdata[lvt_pkg::CMD_GET_FIRST_BIT];
      next_lookup_cmd.get_next  =
        I_REG_REQ.wdata[lvt_pkg::CMD_GET_NEXT_BIT];
    end
    // clear first so a same-cycle make command still sets pending
    if (I_MAKE_DONE) begin
      next_make_pending = 1'b0; // R7
    end
    if (next_lookup_cmd.make) begin
      next_make_pending = 1'b1; // R7
    end
    if (next_lookup_cmd.get_first || next_lookup_cmd.get_next) begin
      next_entry_valid  = 1'b0; // R15
      next_end_of_table = 1'b0;
    end
    if (I_ENTRY_FOUND) begin
      next_entry_valid = 1'b1; // R15
      next_entry       = I_ENTRY; // R1 R2
    end
    if (I_END_OF_TABLE) begin
      next_end_of_table = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      init_done    <= 1'b0; // R3
      age_test     <= 1'b0; // R8
      make_pending <= 1'b0;
      entry_valid  <= 1'b0;
      end_of_table <= 1'b0;
      entry        <= '0;
      O_LOOKUP_CMD <= '0;
      O_RX_DROP    <= 1'b1;
      O_AGE_TICK   <= 1'b0;
    end else begin
      init_done    <= next_init_done;
      age_test     <= next_age_test;
      make_pending <= next_make_pending;
      entry_valid  <= next_entry_valid;
      end_of_table <= next_end_of_table;
      entry        <= next_entry;
      O_LOOKUP_CMD <= next_lookup_cmd;
      O_RX_DROP    <= !next_init_done; // R5
      O_AGE_TICK   <= age_expire;
    end
  end

  // VLAN / port VID table access sequencer
  always_comb begin
    next_vstate     = vstate;
    next_vwait      = vwait;
    next_vlan_cmd   = vlan_cmd;
    next_vlan_rdata = vlan_rdata;
    next_vlan_wdata = vlan_wdata;
    next_vlan_tab   = vlan_tab;
    next_pvid_tab   = pvid_tab;
    if (I_REG_REQ.wr && I_REG_REQ.addr == lvt_pkg::VLAN_WDATA_ADDR) begin
      next_vlan_wdata = I_REG_REQ.wdata[VW-1:0]; // R11
    end
    case (vstate)
      lvt_pkg::VLAN_IDLE: begin
        if (vlan_accept) begin
          next_vlan_cmd.rnw      =
            I_REG_REQ.wdata[lvt_pkg::ACCESS_DIRECTION_BIT]; // R12
          next_vlan_cmd.pvid_sel =
            I_REG_REQ.wdata[lvt_pkg::VLAN_SEL_BIT]; // R13
          next_vlan_cmd.index    =
            I_REG_REQ.wdata[lvt_pkg::VLAN_IDX_LSB +: lvt_pkg::VLAN_IDX_W];
          next_vwait  = lvt_pkg::VLAN_ACCESS_CYCLES - 2'h1;
          next_vstate = lvt_pkg::VLAN_BUSY; // R9 R10
        end
      end
      lvt_pkg::VLAN_BUSY: begin
        if (vwait != 2'h0) begin
          next_vwait = vwait - 2'h1;
        end else begin
          next_vstate = lvt_pkg::VLAN_IDLE; // R10 R11
          // out-of-range port index reads zero, writes nothing
          if (vlan_cmd.pvid_sel) begin // R13 R14
            if (vlan_cmd.index < 4'(lvt_pkg::PVID_ENTRIES)) begin
              if (vlan_cmd.rnw) begin
                next_vlan_rdata =
                  VW'(pvid_tab[vlan_cmd.index[1:0]]);
              end else begin
                next_pvid_tab[vlan_cmd.index[1:0]] = vlan_wdata[PW-1:0];
              end
            end else if (vlan_cmd.rnw) begin
              next_vlan_rdata = '0;
            end
          end else if (vlan_cmd.rnw) begin
            next_vlan_rdata = vlan_tab[vlan_cmd.index];
          end else begin
            next_vlan_tab[vlan_cmd.index] = vlan_wdata;
          end
        end
      end
      default: begin
        next_vstate = lvt_pkg::VLAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vstate     <= lvt_pkg::VLAN_IDLE;
      vwait      <= 2'h0;
      vlan_cmd   <= '0; // R12
      vlan_rdata <= '0;
      vlan_wdata <= '0;
      for (int i = 0; i < lvt_pkg::VLAN_ENTRIES; i++) begin
        vlan_tab[i] <= lvt_pkg::VLAN_RESET;
      end
      for (int i = 0; i < lvt_pkg::PVID_ENTRIES; i++) begin
        pvid_tab[i] <= lvt_pkg::PVID_RESET;
      end
    end else begin
      vstate     <= next_vstate;
      vwait      <= next_vwait;
      vlan_cmd   <= next_vlan_cmd;
      vlan_rdata <= next_vlan_rdata;
      vlan_wdata <= next_vlan_wdata;
      vlan_tab   <= next_vlan_tab;
      pvid_tab   <= next_pvid_tab;
    end
  end

  // read mux; unmapped numbers read zero
  always_comb begin
    next_rdata = lvt_pkg::READ_ZERO;
    case (I_REG_REQ.addr)
      lvt_pkg::READ_LOWER_ADDR: next_rdata = entry.mac_first;
      lvt_pkg::READ_UPPER_ADDR: begin
        next_rdata = {5'h00, entry_valid, end_of_table, entry.is_static,
                      entry.filter, entry.prio_en, entry.prio,
                      entry.port, entry.mac_last}; // R1 R2
      end
      lvt_pkg::STATUS_ADDR: begin
        next_rdata[lvt_pkg::STS_INIT_DONE_BIT] = init_done; // R3
        next_rdata[lvt_pkg::STS_MAKE_PEND_BIT] = make_pending; // R7
      end
      lvt_pkg::CONFIG_ADDR: begin
        next_rdata[lvt_pkg::CFG_AGE_TEST_BIT] = age_test;
      end
      lvt_pkg::VLAN_CMD_ADDR: next_rdata = 32'(vlan_cmd);
      lvt_pkg::VLAN_WDATA_ADDR: next_rdata = 32'(vlan_wdata);
      lvt_pkg::VLAN_RDATA_ADDR: next_rdata = 32'(vlan_rdata); // R10
      lvt_pkg::VLAN_STATUS_ADDR: begin
        next_rdata[lvt_pkg::VLAN_PEND_BIT] = vlan_pend; // R10
      end
      default: next_rdata = lvt_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= 32'h00000000;
      O_REG_ACK   <= 1'b0;
    end else begin
      O_REG_RDATA <= I_REG_REQ.rd ? next_rdata : 32'h00000000;
      O_REG_ACK   <= I_REG_REQ.rd | I_REG_REQ.wr;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  init_sets_a: assert property (init_expire |=> init_done) // R3
    else $error("init done did not set after init");
  init_holds_a: assert property ( // R3
    !init_done && !init_expire |=> !init_done)
    else $error("init done set early");
  // drop and init_done load from the same next value, so same cycle
  init_drop_a: assert property ( // R5
    !init_done |-> O_RX_DROP)
    else $error("packets not dropped during init");
  init_time_a: assert property ( // R4
    $fell(O_RX_DROP) |-> $past(init_expire))
    else $error("drop ended without init expiry");
  make_set_a: assert property ( // R7
    wr_cmd && I_REG_REQ.wdata[lvt_pkg::CMD_MAKE_BIT] |=> make_pending)
    else $error("make pending not set");
  make_clr_a: assert property ( // R7
    make_pending && I_MAKE_DONE
    && !(wr_cmd && I_REG_REQ.wdata[lvt_pkg::CMD_MAKE_BIT])
    |=> !make_pending)
    else $error("make pending not cleared");
  vlan_busy_a: assert property ( // R9
    vlan_accept |=> vlan_pend [*2] ##1 !vlan_pend)
    else $error("vlan access length wrong");
  vlan_ignore_a: assert property ( // R16
    vlan_pend && wr_vlan_cmd |=> $stable(vlan_cmd))
    else $error("command changed during access");
  vlan_dir_a: assert property ( // R12
    vlan_accept |=> vlan_cmd.rnw == $past(I_REG_REQ.wdata[5])
                 && vlan_cmd.pvid_sel == $past(I_REG_REQ.wdata[4]))
    else $error("direction or table select not latched");
  valid_clr_a: assert property ( // R15
    (O_LOOKUP_CMD.get_first || O_LOOKUP_CMD.get_next) && !I_ENTRY_FOUND
    |-> !entry_valid || $past(I_ENTRY_FOUND))
    else $error("valid not cleared by get command");
  valid_set_a: assert property ( // R15
    I_ENTRY_FOUND |=> entry_valid
                      && entry.mac_last == $past(I_ENTRY.mac_last)
                      && entry.port == $past(I_ENTRY.port))
    else $error("found entry not captured");
  age_period_a: assert property ( // R8
    O_AGE_TICK && $past(age_test) && $past(age_test, 2)
    |-> $past(age_period) == AGE_TEST_CYCLES)
    else $error("aging test period not applied");

  init_done_c: cover property ($rose(init_done));
  vlan_read_c: cover property (vlan_accept && I_REG_REQ.wdata[5]
                               ##3 !vlan_pend);
  make_done_c: cover property (make_pending ##1 !make_pending);
  busy_write_c: cover property (vlan_pend && wr_vlan_cmd);

endmodule
`default_nettype wire

// [test_lookup_table_vlan_access.sv]
`timescale 1ns/1ps
`default_nettype none
module test_lookup_table_vlan_access;
  // short aging periods keep the run small
  localparam logic [39:0] AGE_N = 40'h0000000014;
  localparam logic [39:0] AGE_T = 40'h000000000A;

  logic                      clk;
  logic                      rst_n;
  lvt_pkg::lvt_reg_req_t     req;
  logic [31:0]               rdata;
  logic                      ack;
  lvt_pkg::lvt_entry_t       ent;
  logic                      found;
  logic                      eot;
  logic                      mdone;
  lvt_pkg::lvt_lookup_cmd_t  cmd;
  lvt_pkg::lvt_lookup_cmd_t  cmd_seen;
  logic                      drop;
  logic                      tick;
  logic [31:0]               rv;
  int                        err_count;
  int                        checks_done;
  int                        cyc;
  int                        fall_at;
  int                        g;

  lvt_regs #(
    .AGE_NORMAL_CYCLES (AGE_N),
    .AGE_TEST_CYCLES   (AGE_T)
  ) dut (
    .I_MCLK         (clk),
    .I_RST_N        (rst_n),
    .I_REG_REQ      (req),
    .O_REG_RDATA    (rdata),
    .O_REG_ACK      (ack),
    .I_ENTRY        (ent),
    .I_ENTRY_FOUND  (found),
    .I_END_OF_TABLE (eot),
    .I_MAKE_DONE    (mdone),
    .O_LOOKUP_CMD   (cmd),
    .O_RX_DROP      (drop),
    .O_AGE_TICK     (tick)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // edges since reset release, and the edge at which dropping stopped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end
  always @(negedge clk) begin
    if (!rst_n) fall_at = 0;
    else if (!drop && fall_at == 0) fall_at = cyc;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one request cycle; returns just after the edge that takes it
  task automatic drive(input logic r, input logic [15:0] a,
                       input logic [31:0] d);
    req = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk);
    #2;
  endtask

  // strobe, answer next cycle, one idle cycle after
  task automatic bus(input logic r, input logic [15:0] a,
                     input logic [31:0] d);
    drive(r, a, d);
    req = '0;
    check(32'(ack), 32'h1);
    rv = rdata;
    cmd_seen = cmd;
    @(posedge clk);
    #2;
    check(32'(ack), 32'h0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    check(rv, exp);
  endtask

  // bounded poll of the vlan pending flag
  task automatic wait_idle();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, lvt_pkg::VLAN_STATUS_ADDR, 32'h0);
      if (rv[0] === 1'b0) break;
    end
    check(rv, 32'h0);
  endtask

  task automatic vlan_read(input logic s, input logic [3:0] i,
                           input logic [31:0] exp);
    bus(1'b0, lvt_pkg::VLAN_CMD_ADDR, {26'h0, 1'b1, s, i});
    wait_idle();
    rd(lvt_pkg::VLAN_CMD_ADDR, {26'h0, 1'b1, s, i});
    rd(lvt_pkg::VLAN_RDATA_ADDR, exp);
  endtask

  // data register loaded before the command, as software must
  task automatic vlan_xfer(input logic s, input logic [3:0] i,
                           input logic [31:0] d);
    bus(1'b0, lvt_pkg::VLAN_WDATA_ADDR, d);
    rd(lvt_pkg::VLAN_WDATA_ADDR, d);
    bus(1'b0, lvt_pkg::VLAN_CMD_ADDR, {26'h0, 1'b0, s, i});
    wait_idle();
    vlan_read(s, i, d);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #2;
    check(32'(drop), 32'h1);
    rst_n = 1'b1;
  endtask

  // gap in edges between two consecutive aging ticks
  task automatic measure(output int gap);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    gap = 0;
    do begin
      @(posedge clk);
      #2;
      gap++;
    end while (tick !== 1'b1 && gap < 100);
  endtask

  // watchdog well beyond the roughly 1,300 cycles the tests need
  initial begin
    #(40 * 20000);
    err_count++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    ent = '0;
    found = 1'b0;
    eot = 1'b0;
    mdone = 1'b0;
    err_count = 0;
    checks_done = 0;
    #2;
    do_reset();
    rd(lvt_pkg::STATUS_ADDR, 32'h0);
    rd(lvt_pkg::CONFIG_ADDR, 32'h0);
    rd(16'h1800, 32'h0);
    repeat (510) @(posedge clk);
    #2;
    check(32'(fall_at), 32'd501);
    rd(lvt_pkg::STATUS_ADDR, 32'h2);
    bus(1'b0, lvt_pkg::STATUS_ADDR, 32'h0);
    rd(lvt_pkg::STATUS_ADDR, 32'h2);
    // aging period, normal then shortened
    measure(g);
    check(32'(g), 32'd20);
    bus(1'b0, lvt_pkg::CONFIG_ADDR, 32'h1);
    rd(lvt_pkg::CONFIG_ADDR, 32'h1);
    measure(g);
    check(32'(g), 32'd10);
    // every port code, including the reserved one, read back
    for (int p = 0; p < 8; p++) begin
      bus(1'b0, lvt_pkg::LOOKUP_CMD_ADDR, 32'h2);
      check(32'(cmd_seen), 32'h2);
      // get clears the flags only; fields of the last entry remain
      rd(lvt_pkg::READ_UPPER_ADDR, {5'h0, 2'b00, ent.is_static,
         ent.filter, ent.prio_en, ent.prio, ent.port,
         ent.mac_last});
      ent = '{mac_first: 32'hA5000000 | p, is_static: p[0],
              filter: p[1], prio_en: p[2], prio: 3'(7 - p),
              port: 3'(p), mac_last: 16'(16'h8001 ^ (p << 4))};
      found = 1'b1;
      @(posedge clk);
      #2;
      found = 1'b0;
      rd(lvt_pkg::READ_UPPER_ADDR, {5'h0, 2'b10, ent.is_static,
         ent.filter, ent.prio_en, ent.prio, ent.port,
         ent.mac_last});
      rd(lvt_pkg::READ_LOWER_ADDR, ent.mac_first);
    end
    bus(1'b0, lvt_pkg::LOOKUP_CMD_ADDR, 32'h1);
    check(32'(cmd_seen), 32'h1);
    eot = 1'b1;
    @(posedge clk);
    #2;
    eot = 1'b0;
    bus(1'b1, lvt_pkg::READ_UPPER_ADDR, 32'h0);
    check(32'(rv[26:25]), 32'h1);
    // entry creation pending until done
    bus(1'b0, lvt_pkg::LOOKUP_CMD_ADDR, 32'h4);
    check(32'(cmd_seen), 32'h4);
    rd(lvt_pkg::STATUS_ADDR, 32'h3);
    mdone = 1'b1;
    @(posedge clk);
    #2;
    mdone = 1'b0;
    rd(lvt_pkg::STATUS_ADDR, 32'h2);
    // table reset contents, then both tables at edge indices
    vlan_read(1'b1, 4'h1, 32'h1);
    vlan_read(1'b0, 4'h5, 32'h0);
    vlan_xfer(1'b0, 4'h0, 32'h3FFFF);
    vlan_xfer(1'b0, 4'hF, 32'h2A5A5);
    vlan_xfer(1'b1, 4'h0, 32'h7ABC);
    vlan_xfer(1'b1, 4'h2, 32'h5001);
    vlan_read(1'b0, 4'h0, 32'h3FFFF);
    // second command while pending, then status at once
    drive(1'b0, lvt_pkg::VLAN_CMD_ADDR, 32'h23);
    drive(1'b0, lvt_pkg::VLAN_CMD_ADDR, 32'h1F);
    drive(1'b1, lvt_pkg::VLAN_STATUS_ADDR, 32'h0);
    req = '0;
    check(rdata, 32'h1);
    @(posedge clk);
    #2;
    wait_idle();
    rd(lvt_pkg::VLAN_CMD_ADDR, 32'h23);
    // reset in mid-run reruns table init
    do_reset();
    rd(lvt_pkg::STATUS_ADDR, 32'h0);
    rd(lvt_pkg::CONFIG_ADDR, 32'h0);
    repeat (510) @(posedge clk);
    #2;
    check(32'(fall_at), 32'd501);
    rd(lvt_pkg::STATUS_ADDR, 32'h2);
    conclude();
  end
endmodule
`default_nettype wire
